//--- core/pwm_prot_cfg.svh
// Offsets, field positions, reset values and timing counts of the protection block
`ifndef PWM_PROT_CFG_SVH
`define PWM_PROT_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ADDR_CLK       10'h000
`define ADDR_DIS       10'h008
`define ADDR_SCM       10'h020
`define ADDR_FMR       10'h05c
`define ADDR_FSR       10'h060
`define ADDR_CLR       10'h064
`define ADDR_LVL       10'h068
`define ADDR_RTE       10'h06c
`define ADDR_EL0       10'h080
`define ADDR_EL1       10'h084
`define ADDR_STEP      10'h0b0
`define ADDR_LCMD      10'h0e4
`define ADDR_LSTA      10'h0e8

// Per-channel window: 0x200 + ch * 0x20
`define CH_WIN_TAG     3'h4
`define CH_CMR         5'h00
`define CH_PRD         5'h0c
`define CH_PRDUPD      5'h10
`define CH_DT          5'h18
`define CH_DTUPD       5'h1c

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define UNLOCK_KEY     24'h50574d
`define GROUP_NONE     3'h7
`define NUM_FAULT      5
`define NUM_CH         4
`define RST_FMR        24'h000000
`define RST_RTE        32'h00000000
`define RST_SEL        8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ        200
`define FILT_TIME_NS   20
`define FILT_CYCLES    (((`FILT_TIME_NS * `CLK_MHZ) + 999) / 1000)

`endif

//--- core/pwm_prot_pkg.sv
// Types shared by the protection block
package pwm_prot_pkg;

   typedef enum logic [1:0]
   {
      CMD_SW_OFF = 2'h0,
      CMD_SW_ON  = 2'h1,
      CMD_HW_ON  = 2'h2,
      CMD_NONE   = 2'h3
   } lock_cmd_type;

   typedef logic [7:0] fault_mask_type;

endpackage

//--- core/fault_filter.sv
// Stability filter for one synchronised fault input
`timescale 1ns/1ps
`include "pwm_prot_cfg.svh"

module fault_filter
(
   input  wire logic mclk_i,
   input  wire logic reset_i,
   input  wire logic sample_i,
   input  wire logic filter_en_i,
   output logic      level_o
);

   logic [3:0] cnt_ff;
   logic       level_ff;
   logic       differs;
   logic       settled;

   assign differs = sample_i ^ level_ff;
   assign settled = (cnt_ff == 4'(`FILT_CYCLES - 1));
   assign level_o = level_ff;

   // With the filter enabled, level follows the input only after it holds for the filter time
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         cnt_ff   <= 4'h0;
         level_ff <= 1'b0;
      end
      else if (!filter_en_i || (differs && settled))
      begin
         cnt_ff   <= 4'h0;
         level_ff <= sample_i;
      end
      else
      begin
         cnt_ff   <= differs ? cnt_ff + 4'h1 : 4'h0;
      end
   end

endmodule

//--- core/gray_stepper.sv
// Two-bit gray sequencer for one channel pair
`timescale 1ns/1ps

module gray_stepper
(
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic       enable_i,
   input  wire logic       down_i,
   input  wire logic       step_i,
   output logic [1:0]      gray_o
);

   logic [1:0] cnt_ff;

   assign gray_o = cnt_ff ^ {1'b0, cnt_ff[1]};

   // Held at the first state while sequencing is off
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || !enable_i)
         cnt_ff <= 2'h0;
      else if (step_i)
         cnt_ff <= down_i ? cnt_ff - 2'h1 : cnt_ff + 2'h1;
   end

endmodule

//--- core/pwm_fault_protect.sv
// Fault protection, event lines, gray stepping and write locking of the PWM controller
//
// Functional notes
// - Fault status shows each fault input level, after the filter when enabled.
// - One readable flag per fault: one while active, zero while inactive.
// - Clear bit ends a latched fault only once its input left the polarity.
// - An active routed fault forces both channel outputs to programmed levels.
// - Eight-bit routing field per channel; only the five low bits count.
// - Protection level and routing writes need group 5 unlocked in both locks.
// - Each event line pulses when any selected comparison unit matches.
// - Per pair an enable starts gray sequencing; companion bit picks down count.
// - Lock commands act only with the correct key; key reads back zero.
// - A lock command touches only groups whose select bit is one.
// - Command codes: 0 soft unlock, 1 soft lock, 2 hard lock, 3 nothing.
// - A hard lock stays until controller reset; commands cannot clear it.
// - Six groups: clock, disable, modes, period, dead time, fault setup.
// - Status shows hard locks in bits 8 to 13, soft locks in 0 to 5.
// - Bit 7 flags any protected write attempt since the last status read.
// - While flagged, bits 16 to 31 hold the attempted offset over four.
// - Reading the status clears the violation flag and source.
// - Fault asserts at polarity; non-latched ends on release, latched needs clear.
// - Per-fault filter bit: zero passes input raw, one filters it.
`timescale 1ns/1ps
`include "pwm_prot_cfg.svh"

module pwm_fault_protect
(
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic [9:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   input  wire logic [4:0]  fault_pin_i,
   input  wire logic [7:0]  cmp_match_i,
   input  wire logic [3:0]  dt_low_i,
   input  wire logic [3:0]  dt_high_i,
   input  wire logic [3:0]  period_end_i,
   output logic [3:0]       low_side_output_o,
   output logic [3:0]       high_side_output_o,
   output logic [1:0]       event_line_o,
   output logic [5:0]       group_open_o
);

   // ---------------------------------------------------------------
   // Protected register decode
   // ---------------------------------------------------------------
   function automatic logic [2:0] group_of(input logic [9:0] a);
      logic [4:0] ofs;
      begin
         ofs      = a[4:0];
         group_of = `GROUP_NONE;
         if (a == `ADDR_CLK)
            group_of = 3'h0;
         else if (a == `ADDR_DIS)
            group_of = 3'h1;
         else if (a == `ADDR_SCM || a == `ADDR_STEP)
            group_of = 3'h2;
         else if (a == `ADDR_FMR || a == `ADDR_LVL || a == `ADDR_RTE)
            group_of = 3'h5;
         else if (a[9:7] == `CH_WIN_TAG)
         begin
            if (ofs == `CH_CMR)
               group_of = 3'h2;
            else if (ofs == `CH_PRD || ofs == `CH_PRDUPD)
               group_of = 3'h3;
            else if (ofs == `CH_DT || ofs == `CH_DTUPD)
               group_of = 3'h4;
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [5:0]                 sw_lock_ff;
   logic [5:0]                 hw_lock_ff;
   logic                       viol_ff;
   logic [15:0]                viol_src_ff;
   logic [23:0]                fmr_ff;
   logic [3:0]                 lvl_low_ff;
   logic [3:0]                 lvl_high_ff;
   logic [31:0]                rte_ff;
   pwm_prot_pkg::fault_mask_type sel_ff [2];
   logic [1:0]                 gray_en_ff;
   logic [1:0]                 down_ff;
   logic [4:0]                 sync1_ff;
   logic [4:0]                 sync2_ff;
   logic [4:0]                 fault_ff;
   logic [31:0]                rdata_ff;
   logic [3:0]                 low_ff;
   logic [3:0]                 high_ff;
   logic [1:0]                 event_ff;
   logic [5:0]                 open_ff;

   // ---------------------------------------------------------------
   // Write qualification
   // ---------------------------------------------------------------
   logic [2:0]                 wr_grp;
   logic [7:0]                 locked_ext;
   logic                       wr_locked;
   logic                       wr_ok;
   logic                       viol_now;
   logic                       lsta_rd;

   assign wr_grp     = group_of(reg_addr_i);
   assign locked_ext = {2'b00, sw_lock_ff | hw_lock_ff};
   assign wr_locked  = locked_ext[wr_grp];
   assign wr_ok      = reg_wr_i & ~wr_locked;
   assign viol_now   = reg_wr_i & wr_locked;
   assign lsta_rd    = reg_rd_i && (reg_addr_i == `ADDR_LSTA);

   logic                       wr_fmr;
   logic                       wr_lvl;
   logic                       wr_rte;
   logic                       wr_step;
   logic                       wr_clr;
   logic [1:0]                 wr_el;

   assign wr_fmr  = wr_ok && (reg_addr_i == `ADDR_FMR);
   assign wr_lvl  = wr_ok && (reg_addr_i == `ADDR_LVL);
   assign wr_rte  = wr_ok && (reg_addr_i == `ADDR_RTE);
   assign wr_step = wr_ok && (reg_addr_i == `ADDR_STEP);
   assign wr_clr  = reg_wr_i && (reg_addr_i == `ADDR_CLR);
   assign wr_el   = {wr_ok && (reg_addr_i == `ADDR_EL1),
                     wr_ok && (reg_addr_i == `ADDR_EL0)};

   // ---------------------------------------------------------------
   // Lock command
   // ---------------------------------------------------------------
   logic                       cmd_hit;
   logic [5:0]                 cmd_sel;
   pwm_prot_pkg::lock_cmd_type cmd_code;
   logic [5:0]                 nxt_sw_lock;
   logic [5:0]                 nxt_hw_lock;

   assign cmd_hit  = reg_wr_i && (reg_addr_i == `ADDR_LCMD)
                     && (reg_wdata_i[31:8] == `UNLOCK_KEY);
   assign cmd_sel  = reg_wdata_i[7:2];
   assign cmd_code = pwm_prot_pkg::lock_cmd_type'(reg_wdata_i[1:0]);

   assign nxt_sw_lock = !cmd_hit ? sw_lock_ff :
                        (cmd_code == pwm_prot_pkg::CMD_SW_OFF) ? (sw_lock_ff & ~cmd_sel) :
                        (cmd_code == pwm_prot_pkg::CMD_SW_ON)  ? (sw_lock_ff | cmd_sel) :
                        sw_lock_ff;
   assign nxt_hw_lock = (cmd_hit && cmd_code == pwm_prot_pkg::CMD_HW_ON) ?
                        (hw_lock_ff | cmd_sel) : hw_lock_ff;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         sw_lock_ff <= 6'h00;
         hw_lock_ff <= 6'h00;
         open_ff    <= 6'h3f;
      end
      else
      begin
         sw_lock_ff <= nxt_sw_lock;
         hw_lock_ff <= nxt_hw_lock;
         open_ff    <= ~(nxt_sw_lock | nxt_hw_lock);
      end
   end

   // ---------------------------------------------------------------
   // Violation tracking
   // ---------------------------------------------------------------
   logic                       nxt_viol;
   logic [15:0]                nxt_viol_src;

   // A new attempt in the reading cycle survives the clear
   assign nxt_viol     = viol_now | (viol_ff & ~lsta_rd);
   assign nxt_viol_src = viol_now ? {8'h00, reg_addr_i[9:2]} :
                         lsta_rd  ? 16'h0000 : viol_src_ff;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         viol_ff     <= 1'b0;
         viol_src_ff <= 16'h0000;
      end
      else
      begin
         viol_ff     <= nxt_viol;
         viol_src_ff <= nxt_viol_src;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         fmr_ff      <= `RST_FMR;
         lvl_low_ff  <= 4'h0;
         lvl_high_ff <= 4'h0;
         rte_ff      <= `RST_RTE;
         gray_en_ff  <= 2'h0;
         down_ff     <= 2'h0;
      end
      else
      begin
         if (wr_fmr)
            fmr_ff <= reg_wdata_i[23:0];
         if (wr_lvl)
         begin
            lvl_low_ff  <= reg_wdata_i[19:16];
            lvl_high_ff <= reg_wdata_i[3:0];
         end
         if (wr_rte)
            rte_ff <= reg_wdata_i;
         if (wr_step)
         begin
            gray_en_ff <= reg_wdata_i[1:0];
            down_ff    <= reg_wdata_i[17:16];
         end
      end
   end

   // ---------------------------------------------------------------
   // Event lines
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : g_event
         always_ff @(posedge mclk_i)
         begin
            if (reset_i)
            begin
               sel_ff[i]   <= `RST_SEL;
               event_ff[i] <= 1'b0;
            end
            else
            begin
               if (wr_el[i])
                  sel_ff[i] <= reg_wdata_i[7:0];
               event_ff[i] <= |(cmp_match_i & sel_ff[i]);
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Fault inputs and fault state
   // ---------------------------------------------------------------
   logic [4:0]                 filt_level;
   logic [4:0]                 fault_pol;
   logic [4:0]                 fault_latch;
   logic [4:0]                 at_pol;
   logic [4:0]                 clear_ok;
   logic [4:0]                 nxt_fault;

   assign fault_pol   = fmr_ff[4:0];
   assign fault_latch = fmr_ff[12:8];
   assign at_pol      = ~(filt_level ^ fault_pol);
   assign clear_ok    = wr_clr ? (reg_wdata_i[4:0] & fault_latch & ~at_pol) : 5'h00;
   assign nxt_fault   = at_pol | (fault_ff & fault_latch & ~clear_ok);

   generate
      for (i = 0; i < `NUM_FAULT; i = i + 1)
      begin : g_filter
         fault_filter u_filter
         (
            .mclk_i      (mclk_i),
            .reset_i     (reset_i),
            .sample_i    (sync2_ff[i]),
            .filter_en_i (fmr_ff[16 + i]),
            .level_o     (filt_level[i])
         );
      end
   endgenerate

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         fault_ff <= 5'h00;
      end
      else
      begin
         sync1_ff <= fault_pin_i;
         sync2_ff <= sync1_ff;
         fault_ff <= nxt_fault;
      end
   end

   // ---------------------------------------------------------------
   // Gray sequencing and output selection
   // ---------------------------------------------------------------
   logic [1:0]                 gray_val [2];
   logic [3:0]                 prot;
   logic [3:0]                 nxt_low;
   logic [3:0]                 nxt_high;

   generate
      for (i = 0; i < 2; i = i + 1)
      begin : g_pair
         gray_stepper u_gray
         (
            .mclk_i   (mclk_i),
            .reset_i  (reset_i),
            .enable_i (gray_en_ff[i]),
            .down_i   (down_ff[i]),
            .step_i   (period_end_i[2 * i]),
            .gray_o   (gray_val[i])
         );
      end

      for (i = 0; i < `NUM_CH; i = i + 1)
      begin : g_chan
         logic gray_bit;
         assign prot[i]     = |(fault_ff & rte_ff[8 * i +: `NUM_FAULT]);
         assign gray_bit    = gray_val[i / 2][i % 2];
         assign nxt_low[i]  = prot[i] ? lvl_low_ff[i] :
                              gray_en_ff[i / 2] ? gray_bit : dt_low_i[i];
         assign nxt_high[i] = prot[i] ? lvl_high_ff[i] :
                              gray_en_ff[i / 2] ? ~gray_bit : dt_high_i[i];
      end
   endgenerate

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         low_ff  <= 4'h0;
         high_ff <= 4'h0;
      end
      else
      begin
         low_ff  <= nxt_low;
         high_ff <= nxt_high;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [31:0]                rd_fsr;
   logic [31:0]                rd_lsta;
   logic [31:0]                rd_mux;

   assign rd_fsr  = {16'h0000, 3'h0, fault_ff, 3'h0, filt_level};
   assign rd_lsta = {viol_src_ff, 2'h0, hw_lock_ff,
                     viol_ff, 1'b0, sw_lock_ff};
   // Write-only and unmapped offsets read zero, key included
   assign rd_mux  = (reg_addr_i == `ADDR_FMR)  ? {8'h00, fmr_ff} :
                    (reg_addr_i == `ADDR_FSR)  ? rd_fsr :
                    (reg_addr_i == `ADDR_LVL)  ? {12'h000, lvl_low_ff, 12'h000, lvl_high_ff} :
                    (reg_addr_i == `ADDR_RTE)  ? rte_ff :
                    (reg_addr_i == `ADDR_EL0)  ? {24'h000000, sel_ff[0]} :
                    (reg_addr_i == `ADDR_EL1)  ? {24'h000000, sel_ff[1]} :
                    (reg_addr_i == `ADDR_STEP) ? {14'h0000, down_ff, 14'h0000, gray_en_ff} :
                    (reg_addr_i == `ADDR_LSTA) ? rd_lsta :
                    32'h00000000;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         rdata_ff <= 32'h00000000;
      else
         rdata_ff <= reg_rd_i ? rd_mux : 32'h00000000;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata_o        = rdata_ff;
   assign low_side_output_o  = low_ff;
   assign high_side_output_o = high_ff;
   assign event_line_o       = event_ff;
   assign group_open_o       = open_ff;

endmodule

//--- verification/pwm_fault_protect_checker.sv
// Port-level assertions for the fault protection and write lock block
`timescale 1ns/1ps
`include "pwm_prot_cfg.svh"

module pwm_fault_protect_checker
(
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic [9:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [31:0] reg_rdata_o,
   input  wire logic [4:0]  fault_pin_i,
   input  wire logic [7:0]  cmp_match_i,
   input  wire logic [3:0]  dt_low_i,
   input  wire logic [3:0]  dt_high_i,
   input  wire logic [3:0]  period_end_i,
   input  wire logic [3:0]  low_side_output_o,
   input  wire logic [3:0]  high_side_output_o,
   input  wire logic [1:0]  event_line_o,
   input  wire logic [5:0]  group_open_o
);
   logic       st_rd_ff;
   logic [5:0] hw_seen_ff;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   // Hard lock bits seen in any status read so far
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         st_rd_ff   <= 1'b0;
         hw_seen_ff <= 6'h00;
      end
      else
      begin
         st_rd_ff <= reg_rd_i && reg_addr_i == `ADDR_LSTA;
         if (st_rd_ff)
            hw_seen_ff <= hw_seen_ff | reg_rdata_o[13:8];
      end
   end

   AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data outside the answer cycle");
   AST_KEY_ZERO: assert property ((reg_rd_i && reg_addr_i == `ADDR_LCMD) |=>
      reg_rdata_o == 32'h0) else $error("lock command reads nonzero");
   AST_STATUS_LAYOUT: assert property ((reg_rd_i && reg_addr_i == `ADDR_LSTA) |=>
      reg_rdata_o[15:14] == 2'b00 && !reg_rdata_o[6]) else $error("status spare bits set");
   AST_OPEN_MATCH: assert property ((reg_rd_i && reg_addr_i == `ADDR_LSTA &&
      !$past(reg_wr_i)) |=> (reg_rdata_o[5:0] | reg_rdata_o[13:8]) == ~$past(group_open_o))
      else $error("lock status disagrees with open groups");
   AST_FSR_LAYOUT: assert property ((reg_rd_i && reg_addr_i == `ADDR_FSR) |=>
      reg_rdata_o[31:13] == 19'h0 && reg_rdata_o[7:5] == 3'h0)
      else $error("fault status spare bits set");
   AST_VIOL_CLEAR: assert property ((reg_rd_i && reg_addr_i == `ADDR_LSTA) ##1
      !reg_wr_i ##1 (reg_rd_i && reg_addr_i == `ADDR_LSTA) |=>
      !reg_rdata_o[7] && reg_rdata_o[31:16] == 16'h0) else $error("violation not cleared");
   AST_EVENT_IDLE: assert property (cmp_match_i == 8'h00 |=> event_line_o == 2'b00)
      else $error("event without a match");
   AST_OPEN_RESET: assert property ($fell(reset_i) |-> group_open_o == 6'h3f)
      else $error("locks survive reset");
   AST_HW_STICKY: assert property (st_rd_ff |->
      (reg_rdata_o[13:8] & hw_seen_ff) == hw_seen_ff) else $error("hard lock dropped");
endmodule

bind pwm_fault_protect pwm_fault_protect_checker u_pwm_fault_protect_checker (.*);

//--- verification/fault_pin_model.sv
// Behavioural fault source in front of the fault input pins
`timescale 1ns/1ps

module fault_pin_model
(
   input  wire logic       mclk_i,
   input  wire logic [4:0] want_i,
   input  wire logic [3:0] lag_i,
   output logic [4:0]      fault_pin_o
);
   logic [4:0] line_ff [15];

   // Delay line lets the source react at once or many cycles late
   always_ff @(posedge mclk_i)
   begin
      line_ff[0] <= want_i;
      for (int i = 1; i < 15; i++)
      begin
         line_ff[i] <= line_ff[i - 1];
      end
   end

   assign fault_pin_o = (lag_i == 4'h0) ? want_i : line_ff[lag_i - 4'h1];
endmodule

//--- verification/pwm_fault_protect_bench.sv
// Self-checking bench for the fault protection and write lock block
`timescale 1ns/1ps
`include "pwm_prot_cfg.svh"

module pwm_fault_protect_bench;
   logic        mclk_i       = 1'b0;
   logic        reset_i      = 1'b1;
   logic [9:0]  reg_addr_i   = 10'h000;
   logic [31:0] reg_wdata_i  = 32'h0;
   logic        reg_wr_i     = 1'b0;
   logic        reg_rd_i     = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [4:0]  fault_pin_i;
   logic [7:0]  cmp_match_i  = 8'h00;
   logic [3:0]  period_end_i = 4'h0;
   logic [3:0]  low_side;
   logic [3:0]  high_side;
   logic [1:0]  event_line;
   logic [5:0]  group_open;
   logic [4:0]  want         = 5'h00;
   logic [3:0]  lag          = 4'h0;
   logic [7:0]  dt           = 8'h00;
   logic [31:0] d;
   int          errors       = 0;
   int          checked      = 0;

   always #2.5 mclk_i = ~mclk_i;

   fault_pin_model u_fault_pin_model (.mclk_i(mclk_i), .want_i(want), .lag_i(lag),
      .fault_pin_o(fault_pin_i));
   pwm_fault_protect u_pwm_fault_protect (.mclk_i(mclk_i), .reset_i(reset_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fault_pin_i(fault_pin_i),
      .cmp_match_i(cmp_match_i), .dt_low_i(dt[3:0]), .dt_high_i(dt[7:4]),
      .period_end_i(period_end_i), .low_side_output_o(low_side),
      .high_side_output_o(high_side), .event_line_o(event_line), .group_open_o(group_open));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [9:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
      chk(what, exp, d);
   endtask

   task automatic outs(input logic [7:0] exp);
      chk("outputs", {24'h0, exp}, {24'h0, high_side, low_side});
   endtask

   task automatic open(input logic [5:0] exp);
      idle(2);
      chk("group_open", {26'h0, exp}, {26'h0, group_open});
   endtask

   task automatic pins(input logic [4:0] w, input int n);
      @(posedge mclk_i);
      want <= w;
      idle(n);
   endtask

   task automatic cmd(input logic [23:0] k, input logic [5:0] g,
                      input pwm_prot_pkg::lock_cmd_type c);
      wr(`ADDR_LCMD, {k, g, c});
   endtask

   task automatic test_reset;
      logic [9:0] a [7] = '{`ADDR_LVL, `ADDR_RTE, `ADDR_EL0, `ADDR_EL1, `ADDR_STEP,
                            `ADDR_LSTA, 10'h0f0};
      for (int i = 0; i < 7; i++)
      begin
         rdchk("reset value", a[i], 32'h0);
      end
      open(6'h3f);
      $display("test_reset done");
   endtask

   task automatic ev(input logic [7:0] m, input logic [1:0] e);
      @(posedge mclk_i);
      cmp_match_i <= m;
      @(posedge mclk_i);
      cmp_match_i <= 8'h00;
      #1 chk("event", {30'h0, e}, {30'h0, event_line});
      idle(1);
      chk("event end", 32'h0, {30'h0, event_line});
   endtask

   task automatic test_event;
      wr(`ADDR_EL0, 32'h05);
      wr(`ADDR_EL1, 32'h80);
      rdchk("line 1 mask", `ADDR_EL1, 32'h80);
      ev(8'h04, 2'b01);
      ev(8'h80, 2'b10);
      ev(8'h02, 2'b00);
      ev(8'h81, 2'b11);
      $display("test_event done");
   endtask

   task automatic test_gray;
      logic [1:0] c0;
      logic [1:0] c1;
      logic [3:0] lo;
      wr(`ADDR_STEP, 32'h00020003);
      rdchk("stepper mode", `ADDR_STEP, 32'h00020003);
      for (int i = 0; i < 6; i++)
      begin
         if (i > 0)
         begin
            @(posedge mclk_i);
            period_end_i <= 4'h5;
            @(posedge mclk_i);
            period_end_i <= 4'h0;
         end
         idle(3);
         c0 = 2'(i);
         c1 = 2'(0 - i);
         lo = {c1 ^ (c1 >> 1), c0 ^ (c0 >> 1)};
         outs({~lo, lo});
      end
      wr(`ADDR_STEP, 32'h0);
      idle(3);
      outs(8'h00);
      $display("test_gray done");
   endtask

   task automatic test_faults;
      wr(`ADDR_FMR, 32'h0000001f);
      idle(12);
      wr(`ADDR_FMR, 32'h0004021f);
      wr(`ADDR_LVL, 32'h00010004);
      wr(`ADDR_RTE, 32'h0002e001);
      rdchk("routing", `ADDR_RTE, 32'h0002e001);
      rdchk("fault idle", `ADDR_FSR, 32'h0);
      pins(5'h01, 12);
      rdchk("fault on", `ADDR_FSR, 32'h00000101);
      outs(8'h01);
      pins(5'h00, 12);
      outs(8'h00);
      @(posedge mclk_i);
      lag <= 4'h5;
      pins(5'h02, 20);
      rdchk("latched on", `ADDR_FSR, 32'h00000202);
      outs(8'h40);
      @(posedge mclk_i);
      dt <= 8'hff;
      idle(2);
      outs(8'hfb);
      @(posedge mclk_i);
      dt <= 8'h00;
      wr(`ADDR_CLR, 32'h2);
      rdchk("clear at level", `ADDR_FSR, 32'h00000202);
      pins(5'h00, 20);
      rdchk("latched held", `ADDR_FSR, 32'h00000200);
      wr(`ADDR_CLR, 32'h0);
      rdchk("zero clear", `ADDR_FSR, 32'h00000200);
      wr(`ADDR_CLR, 32'h2);
      rdchk("cleared", `ADDR_FSR, 32'h0);
      outs(8'h00);
      @(posedge mclk_i);
      lag <= 4'h0;
      pins(5'h04, 2);
      pins(5'h00, 16);
      rdchk("glitch", `ADDR_FSR, 32'h0);
      pins(5'h04, 20);
      rdchk("filtered", `ADDR_FSR, 32'h00000404);
      outs(8'h00);
      pins(5'h00, 20);
      $display("test_faults done");
   endtask

   task automatic test_lock;
      logic [9:0] p [12] = '{10'h000, 10'h008, 10'h020, 10'h0b0, 10'h200, 10'h20c,
                             10'h230, 10'h238, 10'h27c, 10'h05c, 10'h068, 10'h06c};
      cmd(24'h123456, 6'h20, pwm_prot_pkg::CMD_SW_ON);
      open(6'h3f);
      rdchk("key", `ADDR_LCMD, 32'h0);
      cmd(`UNLOCK_KEY, 6'h3f, pwm_prot_pkg::CMD_SW_ON);
      open(6'h00);
      rdchk("soft locks", `ADDR_LSTA, 32'h0000003f);
      for (int i = 0; i < 12; i++)
      begin
         wr(p[i], 32'hffffffff);
         rdchk("violation", `ADDR_LSTA, {8'h00, p[i][9:2], 16'h00bf});
         rdchk("after read", `ADDR_LSTA, 32'h0000003f);
      end
      rdchk("locked levels", `ADDR_LVL, 32'h00010004);
      cmd(`UNLOCK_KEY, 6'h33, pwm_prot_pkg::CMD_SW_OFF);
      open(6'h33);
      cmd(`UNLOCK_KEY, 6'h3f, pwm_prot_pkg::CMD_NONE);
      open(6'h33);
      cmd(`UNLOCK_KEY, 6'h01, pwm_prot_pkg::CMD_HW_ON);
      open(6'h32);
      rdchk("hard lock", `ADDR_LSTA, 32'h0000010c);
      cmd(`UNLOCK_KEY, 6'h3f, pwm_prot_pkg::CMD_SW_OFF);
      open(6'h3e);
      wr(10'h000, 32'h1);
      rdchk("hard violation", `ADDR_LSTA, 32'h00000180);
      wr(`ADDR_LVL, 32'h000f000f);
      rdchk("open levels", `ADDR_LVL, 32'h000f000f);
      $display("test_lock done");
   endtask

   task automatic test_rereset;
      @(posedge mclk_i);
      reset_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      open(6'h3f);
      rdchk("status after reset", `ADDR_LSTA, 32'h0);
      $display("test_rereset done");
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge mclk_i);
      errors++;
      results();
   end

   initial
   begin
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      test_reset();
      test_event();
      test_gray();
      test_faults();
      test_lock();
      test_rereset();
      results();
   end
endmodule
